/* asr_pkg.sv */
// Shared constants, types and register map of the serial alarm and reset controller.
package asr_pkg;

  localparam int ASR_CODE_W = 18;
  localparam int ASR_HYST_W = 8;
  localparam int ASR_TMR_W = 12;

  // Register offsets on the plain register port.
  localparam logic [7:0] ASR_OFS_HIGH_TH = 8'h00;
  localparam logic [7:0] ASR_OFS_LOW_TH = 8'h04;
  localparam logic [7:0] ASR_OFS_OUT_CTL = 8'h08;
  localparam logic [7:0] ASR_OFS_RST_PWR = 8'h0C;
  localparam logic [7:0] ASR_OFS_ALARM = 8'h10;
  localparam logic [7:0] ASR_OFS_STATUS = 8'h14;

  // Field positions.
  localparam int ASR_HYST_LSB = 24;
  localparam int ASR_RST_TYPE_BIT = 0;
  localparam int ASR_IN_DIS_BIT = 1;
  localparam int ASR_SUP_DIS_BIT = 2;
  localparam logic [1:0] ASR_PIN_ALARM = 2'h1;

  // Values after reset.
  localparam logic [31:0] ASR_RST_HIGH_TH = 32'h0003FFFF;
  localparam logic [31:0] ASR_RST_LOW_TH = 32'h00000000;
  localparam logic [31:0] ASR_RST_OUT_CTL = 32'h00000000;
  localparam logic [31:0] ASR_RST_RST_PWR = 32'h00000000;

  // Fixed supply trip points of the analog comparators, in millivolts.
  localparam int ASR_SUP_HIGH_MV = 5300;
  localparam int ASR_SUP_LOW_MV = 4700;

  // Frame length and timing.
  localparam int ASR_WORD_BITS = 32;
  localparam int ASR_CLK_MHZ = 200;
  localparam int ASR_CONV_NS = 665;
  localparam int ASR_APP_DELAY_NS = 1000;
  localparam int ASR_POR_DELAY_NS = 20000;
  localparam int ASR_CONV_CYC = (ASR_CONV_NS * ASR_CLK_MHZ + 999) / 1000;
  localparam int ASR_APP_DELAY_CYC = (ASR_APP_DELAY_NS * ASR_CLK_MHZ + 999) / 1000;
  localparam int ASR_POR_DELAY_CYC = (ASR_POR_DELAY_NS * ASR_CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    ASR_ST_RESET,
    ASR_ST_ACQ,
    ASR_ST_CONV
  } asr_state_t;

  typedef struct packed {
    logic in_high;
    logic in_low;
    logic sup_high;
    logic sup_low;
  } asr_alarm_t;

endpackage : asr_pkg

/* asr_sync.sv */
// Two-stage synchroniser for a group of asynchronous levels.
`timescale 1ns/1ps
module asr_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule : asr_sync

/* asr_alarm_eval.sv */
// Input alarm flags with hysteresis and supply alarm flags, updated at each conversion end.
`timescale 1ns/1ps
module asr_alarm_eval
  import asr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clear_all_i,
  input wire logic eval_i,
  input wire logic [ASR_CODE_W-1:0] code_i,
  input wire logic [ASR_CODE_W-1:0] high_th_i,
  input wire logic [ASR_CODE_W-1:0] low_th_i,
  input wire logic [ASR_HYST_W-1:0] hyst_i,
  input wire logic sup_high_i,
  input wire logic sup_low_i,
  input wire logic in_dis_i,
  input wire logic sup_dis_i,
  input wire logic tripped_clr_i,
  output asr_alarm_t active_o,
  output asr_alarm_t tripped_o
);
  asr_alarm_t active_q;
  asr_alarm_t active_d;
  asr_alarm_t tripped_q;
  asr_alarm_t tripped_d;
  logic signed [ASR_CODE_W+1:0] code_x;
  logic signed [ASR_CODE_W+1:0] hi_lim;
  logic signed [ASR_CODE_W+1:0] lo_lim;

  always_comb begin
    code_x = $signed({2'h0, code_i});
    hi_lim = $signed({2'h0, high_th_i}) - $signed({12'h000, hyst_i}) - 20'sh00001;
    lo_lim = $signed({2'h0, low_th_i}) + $signed({12'h000, hyst_i}) + 20'sh00001;
    active_d = active_q;
    if (eval_i) begin
      // Hysteresis keeps a flag set until the code clears the band by one step.
      active_d.in_high = (code_i > high_th_i) || (active_q.in_high && (code_x > hi_lim));
      active_d.in_low = (code_i < low_th_i) || (active_q.in_low && (code_x < lo_lim));
      active_d.sup_high = sup_high_i;
      active_d.sup_low = sup_low_i;
      if (in_dis_i) begin
        active_d.in_high = 1'b0;
        active_d.in_low = 1'b0;
      end
      if (sup_dis_i) begin
        active_d.sup_high = 1'b0;
        active_d.sup_low = 1'b0;
      end
    end
    // A new trip in the cycle of a clearing read still sets the flag.
    tripped_d = (tripped_clr_i ? '0 : tripped_q) | (eval_i ? active_d : '0);
    if (clear_all_i) begin
      active_d = '0;
      tripped_d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      active_q <= '0;
      tripped_q <= '0;
    end else begin
      active_q <= active_d;
      tripped_q <= tripped_d;
    end
  end

  assign active_o = active_q;
  assign tripped_o = tripped_q;

  chk_high_set: assert property (@(posedge clk_i) disable iff (reset_i)
    eval_i && !clear_all_i && !in_dis_i && (code_i > high_th_i) |=> active_q.in_high)
    else $error("High alarm not set above threshold.");
  chk_high_release: assert property (@(posedge clk_i) disable iff (reset_i)
    eval_i && !clear_all_i && active_q.in_high && !in_dis_i && (code_x > hi_lim)
    |=> active_q.in_high)
    else $error("High alarm released inside hysteresis band.");
  chk_low_set: assert property (@(posedge clk_i) disable iff (reset_i)
    eval_i && !clear_all_i && !in_dis_i && (code_i < low_th_i) |=> active_q.in_low)
    else $error("Low alarm not set below threshold.");
  chk_low_release: assert property (@(posedge clk_i) disable iff (reset_i)
    eval_i && !clear_all_i && active_q.in_low && (code_x >= lo_lim) |=> !active_q.in_low)
    else $error("Low alarm not released above hysteresis band.");
  chk_tripped_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
    tripped_q.in_high && !tripped_clr_i && !clear_all_i |=> tripped_q.in_high)
    else $error("Tripped flag cleared without a read.");
endmodule : asr_alarm_eval

/* asr_ctrl.sv */
// Serial port, alarm control and reset sequencing of the converter's digital core.
// Notes on behaviour
// - High alarm sets when the code is above the high threshold.
// - High alarm clears when the code is at or below threshold minus hysteresis minus one.
// - Low alarm sets when the code is below the low threshold.
// - Low alarm clears when the code is at or above threshold plus hysteresis plus one.
// - Separate high and low thresholds share one hysteresis value.
// - Supply alarms come from fixed 5.3 V and 4.7 V comparators.
// - Each frame shifts in and out together as one 32-bit register.
// - Input is sampled at serial clock rise; a frame starts at select fall.
// - Launch edges drive the register MSB out; capture edges shift input into LSB.
// - At select rise the register contents are decoded as a command.
// - Three states, reset, acquire, convert, chosen by select and reset pin.
// - Application reset restores configuration, keeps ready low, floats outputs.
// - Power-on reset also clears the alarm flags and needs a longer settle delay.
// - After the release delay the device enters acquire and raises ready.
// - Out of reset, select rise moves acquire to convert; the conversion timer moves convert back to acquire.
// - Active flags are re-evaluated each conversion end; tripped flags stay until read.
// - All alarm flags update once at each conversion end.
// - Select transitions are ignored while a conversion runs.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module asr_ctrl
  import asr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic convert_select_line_i,
  input wire logic sclk_i,
  input wire logic serial_in_pin_i,
  input wire logic reset_pin_n_i,
  input wire logic supply_high_cmp_i,
  input wire logic supply_low_cmp_i,
  input wire logic [ASR_CODE_W-1:0] adc_code_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic serial_out_lane_zero_o,
  output logic serial_out_oe_n_o,
  output logic alarm_multi_function_pin_o,
  output logic alarm_pin_oe_n_o,
  output logic ready_strobe_o,
  output logic conv_start_o,
  output logic [31:0] cmd_word_o,
  output logic cmd_valid_o
);
  logic [5:0] raw_pins;
  logic [5:0] sync_pins;
  logic cs_s;
  logic sclk_s;
  logic sdi_s;
  logic rst_s;
  logic cs_prev_q;
  logic sclk_prev_q;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  asr_state_t st_q, st_d;
  logic [ASR_TMR_W-1:0] tmr_q, tmr_d;
  logic [31:0] shreg_q, shreg_d;
  logic [5:0] bitcnt_q, bitcnt_d;
  logic frame_q, frame_d;
  logic sdo_q, sdo_d;
  logic sdo_oe_n_q, sdo_oe_n_d;
  logic rdy_q, rdy_d;
  logic por_kind_q, por_kind_d;
  logic eval_q, eval_d;
  logic conv_q, conv_d;
  logic [31:0] cmd_q, cmd_d;
  logic cmd_vld_q, cmd_vld_d;
  logic [ASR_CODE_W-1:0] code_q, code_d;

  logic [31:0] high_q, high_d;
  logic [31:0] low_q, low_d;
  logic [31:0] octl_q, octl_d;
  logic [31:0] rpc_q, rpc_d;
  logic [31:0] rdata_q, rdata_d;
  logic pin_q, pin_d;
  logic pin_oe_n_q, pin_oe_n_d;
  logic trip_clr;
  logic clear_all;
  asr_alarm_t active;
  asr_alarm_t tripped;

  // The reset pin and serial pins are asynchronous to clk_i.
  assign raw_pins = {convert_select_line_i, sclk_i, serial_in_pin_i, reset_pin_n_i,
                     supply_high_cmp_i, supply_low_cmp_i};

  asr_sync #(.W(6)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(raw_pins),
    .sync_o(sync_pins)
  );

  assign cs_s = sync_pins[5];
  assign sclk_s = sync_pins[4];
  assign sdi_s = sync_pins[3];
  assign rst_s = sync_pins[2];
  assign cs_fall = cs_prev_q && !cs_s;
  assign cs_rise = !cs_prev_q && cs_s;
  assign sclk_rise = !sclk_prev_q && sclk_s;
  assign sclk_fall = sclk_prev_q && !sclk_s;

  // A power-on reset also wipes the alarm history; an application reset keeps it.
  assign clear_all = !rst_s && por_kind_q && (st_q == ASR_ST_RESET);

  asr_alarm_eval u_alarm (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_all_i(clear_all),
    .eval_i(eval_q),
    .code_i(adc_code_i),
    .high_th_i(high_q[ASR_CODE_W-1:0]),
    .low_th_i(low_q[ASR_CODE_W-1:0]),
    .hyst_i(high_q[ASR_HYST_LSB +: ASR_HYST_W]),
    .sup_high_i(sync_pins[1]),
    .sup_low_i(sync_pins[0]),
    .in_dis_i(rpc_q[ASR_IN_DIS_BIT]),
    .sup_dis_i(rpc_q[ASR_SUP_DIS_BIT]),
    .tripped_clr_i(trip_clr),
    .active_o(active),
    .tripped_o(tripped)
  );

  // Port and state sequencing.
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    shreg_d = shreg_q;
    bitcnt_d = bitcnt_q;
    frame_d = frame_q;
    sdo_d = sdo_q;
    sdo_oe_n_d = sdo_oe_n_q;
    rdy_d = rdy_q;
    por_kind_d = por_kind_q;
    eval_d = 1'b0;
    conv_d = 1'b0;
    cmd_d = cmd_q;
    cmd_vld_d = 1'b0;
    code_d = code_q;
    if (eval_q) begin
      code_d = adc_code_i;
    end
    if (!rst_s) begin
      st_d = ASR_ST_RESET;
      rdy_d = 1'b0;
      sdo_oe_n_d = 1'b1;
      frame_d = 1'b0;
      if (st_q != ASR_ST_RESET) begin
        por_kind_d = !rpc_q[ASR_RST_TYPE_BIT];
      end
      tmr_d = (st_q != ASR_ST_RESET ? !rpc_q[ASR_RST_TYPE_BIT] : por_kind_q)
              ? ASR_TMR_W'(ASR_POR_DELAY_CYC) : ASR_TMR_W'(ASR_APP_DELAY_CYC);
    end else begin
      case (st_q)
        ASR_ST_RESET: begin
          rdy_d = 1'b0;
          if (tmr_q == '0) begin
            st_d = ASR_ST_ACQ;
            rdy_d = 1'b1;
          end else begin
            tmr_d = tmr_q - 1'b1;
          end
        end
        ASR_ST_ACQ: begin
          if (cs_fall) begin
            frame_d = 1'b1;
            rdy_d = 1'b0;
            bitcnt_d = '0;
            shreg_d = {code_q, active, 10'h000};
            sdo_d = code_q[ASR_CODE_W-1];
            sdo_oe_n_d = 1'b0;
          end else begin
            if (frame_q && sclk_rise) begin
              shreg_d = {shreg_q[30:0], sdi_s};
              if (bitcnt_q != 6'h3F) begin
                bitcnt_d = bitcnt_q + 6'h01;
              end
            end
            if (frame_q && sclk_fall) begin
              sdo_d = shreg_q[31];
            end
            if (cs_rise) begin
              // Short frames are kept as no-operation, long ones use the last 32 bits.
              // A rise with no frame before it starts a conversion and hands over nothing.
              frame_d = 1'b0;
              sdo_oe_n_d = 1'b1;
              if (frame_q) begin
                cmd_d = shreg_d;
                cmd_vld_d = bitcnt_d >= 6'(ASR_WORD_BITS);
              end
              st_d = ASR_ST_CONV;
              conv_d = 1'b1;
              tmr_d = ASR_TMR_W'(ASR_CONV_CYC);
              rdy_d = 1'b0;
            end
          end
        end
        ASR_ST_CONV: begin
          // Select edges are not looked at until the conversion finishes.
          if (tmr_q <= ASR_TMR_W'(1)) begin
            tmr_d = '0;
            st_d = ASR_ST_ACQ;
            rdy_d = 1'b1;
            eval_d = 1'b1;
          end else begin
            tmr_d = tmr_q - 1'b1;
          end
        end
        default: begin
          st_d = ASR_ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_q <= ASR_ST_RESET;
      tmr_q <= ASR_TMR_W'(ASR_POR_DELAY_CYC);
      shreg_q <= '0;
      bitcnt_q <= '0;
      frame_q <= 1'b0;
      sdo_q <= 1'b0;
      sdo_oe_n_q <= 1'b1;
      rdy_q <= 1'b0;
      por_kind_q <= 1'b1;
      eval_q <= 1'b0;
      conv_q <= 1'b0;
      cmd_q <= '0;
      cmd_vld_q <= 1'b0;
      code_q <= '0;
      cs_prev_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      shreg_q <= shreg_d;
      bitcnt_q <= bitcnt_d;
      frame_q <= frame_d;
      sdo_q <= sdo_d;
      sdo_oe_n_q <= sdo_oe_n_d;
      rdy_q <= rdy_d;
      por_kind_q <= por_kind_d;
      eval_q <= eval_d;
      conv_q <= conv_d;
      cmd_q <= cmd_d;
      cmd_vld_q <= cmd_vld_d;
      code_q <= code_d;
      cs_prev_q <= cs_s;
      sclk_prev_q <= sclk_s;
    end
  end

  // Register port and alarm pin.
  assign trip_clr = reg_re_i && (reg_addr_i == ASR_OFS_ALARM);

  always_comb begin
    high_d = high_q;
    low_d = low_q;
    octl_d = octl_q;
    rpc_d = rpc_q;
    rdata_d = 32'h00000000;
    if (reg_we_i) begin
      case (reg_addr_i)
        ASR_OFS_HIGH_TH: high_d = reg_wdata_i;
        ASR_OFS_LOW_TH: low_d = reg_wdata_i;
        ASR_OFS_OUT_CTL: octl_d = reg_wdata_i;
        ASR_OFS_RST_PWR: rpc_d = reg_wdata_i;
        default: ;
      endcase
    end
    if (reg_re_i) begin
      case (reg_addr_i)
        ASR_OFS_HIGH_TH: rdata_d = high_q;
        ASR_OFS_LOW_TH: rdata_d = low_q;
        ASR_OFS_OUT_CTL: rdata_d = octl_q;
        ASR_OFS_RST_PWR: rdata_d = rpc_q;
        ASR_OFS_ALARM: rdata_d = {24'h000000, tripped, active};
        ASR_OFS_STATUS: rdata_d = {10'h000, st_q, frame_q, rdy_q, code_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
    // Either reset type returns the configuration to its defaults.
    if (!rst_s) begin
      high_d = ASR_RST_HIGH_TH;
      low_d = ASR_RST_LOW_TH;
      octl_d = ASR_RST_OUT_CTL;
      rpc_d = ASR_RST_RST_PWR;
    end
    pin_oe_n_d = octl_q[1:0] != ASR_PIN_ALARM;
    pin_d = !pin_oe_n_d && (|active);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      high_q <= ASR_RST_HIGH_TH;
      low_q <= ASR_RST_LOW_TH;
      octl_q <= ASR_RST_OUT_CTL;
      rpc_q <= ASR_RST_RST_PWR;
      rdata_q <= '0;
      pin_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else begin
      high_q <= high_d;
      low_q <= low_d;
      octl_q <= octl_d;
      rpc_q <= rpc_d;
      rdata_q <= rdata_d;
      pin_q <= pin_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign serial_out_lane_zero_o = sdo_q;
  assign serial_out_oe_n_o = sdo_oe_n_q;
  assign alarm_multi_function_pin_o = pin_q;
  assign alarm_pin_oe_n_o = pin_oe_n_q;
  assign ready_strobe_o = rdy_q;
  assign conv_start_o = conv_q;
  assign cmd_word_o = cmd_q;
  assign cmd_valid_o = cmd_vld_q;

  chk_frame_start: assert property (@(posedge clk_i) disable iff (reset_i)
    rst_s && (st_q == ASR_ST_ACQ) && cs_fall |=> !ready_strobe_o && !serial_out_oe_n_o)
    else $error("Frame start did not drop ready and drive output.");
  chk_capture_lsb: assert property (@(posedge clk_i) disable iff (reset_i)
    rst_s && (st_q == ASR_ST_ACQ) && frame_q && !cs_fall && sclk_rise
    |=> shreg_q[0] == $past(sdi_s))
    else $error("Captured bit not shifted into the low end.");
  chk_cmd_decode: assert property (@(posedge clk_i) disable iff (reset_i)
    rst_s && (st_q == ASR_ST_ACQ) && frame_q && !cs_fall && cs_rise && !sclk_rise
    |=> cmd_word_o == $past(shreg_q) && cmd_valid_o == ($past(bitcnt_q) >= 6'h20)
        && conv_start_o)
    else $error("Command not handed over at select rise.");
  chk_reset_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
    !rst_s |=> !ready_strobe_o && serial_out_oe_n_o)
    else $error("Outputs active while held in reset.");
  chk_release_ready: assert property (@(posedge clk_i) disable iff (reset_i)
    rst_s && (st_q == ASR_ST_RESET) && (tmr_q == '0) |=> (st_q == ASR_ST_ACQ) && ready_strobe_o)
    else $error("Release delay did not end in acquire with ready high.");
  chk_conv_ignore: assert property (@(posedge clk_i) disable iff (reset_i)
    rst_s && (st_q == ASR_ST_CONV) && (tmr_q > 12'h001) |=> (st_q == ASR_ST_CONV) || !rst_s)
    else $error("Conversion left early.");
  chk_alarm_pin: assert property (@(posedge clk_i) disable iff (reset_i)
    (octl_q[1:0] == ASR_PIN_ALARM) |=> alarm_multi_function_pin_o == $past(|active)
                                      && !alarm_pin_oe_n_o)
    else $error("Alarm pin does not follow active flags.");
endmodule : asr_ctrl

/* asr_host_model.sv */
// Behavioural host that drives the select, serial clock and serial input pins.
`timescale 1ns/1ps
module asr_host_model (
  output logic select_o,
  output logic sclk_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_n_i
);
  localparam realtime HALF = 62.5;
  logic oe_mid;

  // Select and serial clock start low so that the reset pin may be released at once.
  initial begin
    select_o = 1'b0;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    oe_mid = 1'b1;
  end

  task automatic set_select(input logic v);
    select_o = v;
  endtask : set_select

  // Sends n bits MSB first and gathers what comes back, clock held still between frames.
  task automatic frame(input int n, input logic [63:0] din, output logic [63:0] dout);
    dout = '0;
    select_o = 1'b0;
    #HALF;
    for (int i = 0; i < n; i++) begin
      sdi_o = din[n-1-i];
      #HALF;
      sclk_o = 1'b1;
      dout = {dout[62:0], sdo_i};
      if (i == 0) oe_mid = sdo_oe_n_i;
      #HALF;
      sclk_o = 1'b0;
    end
    #HALF;
    select_o = 1'b1;
    // The line is not sampled now, so show the opposite of the last bit.
    sdi_o = ~sdi_o;
  endtask : frame

  // A select pulse inside the conversion time, which the device must not act on.
  task automatic glitch();
    #150;
    select_o = 1'b0;
    #100;
    select_o = 1'b1;
  endtask : glitch
endmodule : asr_host_model

/* adc_serial_alarm_reset_ctrl_bench.sv */
// Self-checking bench of the serial alarm and reset controller.
`timescale 1ns/1ps
module adc_serial_alarm_reset_ctrl_bench;
  import asr_pkg::*;
  logic clk_i, reset_i, sel, sclk, serial_in_pin, reset_pin_n_i, supply_high_cmp_i, supply_low_cmp_i;
  logic [ASR_CODE_W-1:0] adc_code_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, cmd_word_o, last_cmd, v;
  logic reg_we_i, reg_re_i, sdo, sdo_oe_n, alarm_pin, alarm_oe_n, ready, conv_start_o;
  logic cmd_valid_o;
  logic [63:0] din, dout;
  logic [17:0] prev_code;
  logic [3:0] prev_act;
  int failures = 0, samples_checked = 0, cmd_seen = 0, conv_seen = 0, c_cmd, c_conv, n;
  logic [17:0] t_code [11] = '{18'h00100, 18'h00101, 18'h000FC, 18'h000FB, 18'h00050,
    18'h0004F, 18'h00054, 18'h00055, 18'h000C0, 18'h000C0, 18'h00101};
  logic [1:0] t_sup [11] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h1};
  logic [3:0] t_act [11] = '{4'h0, 4'h8, 4'h8, 4'h0, 4'h0, 4'h4, 4'h4, 4'h0, 4'h2, 4'h1, 4'h0};
  // Bit 8 asks for a read of the alarm flags, bits 7-0 give the word expected.
  logic [8:0] t_rd [11] = '{9'h000, 9'h000, 9'h000, 9'h180, 9'h000, 9'h000, 9'h000, 9'h140,
    9'h000, 9'h131, 9'h100};

  asr_ctrl i_asr_ctrl (.clk_i(clk_i), .reset_i(reset_i), .convert_select_line_i(sel),
    .sclk_i(sclk), .serial_in_pin_i(serial_in_pin), .reset_pin_n_i(reset_pin_n_i),
    .supply_high_cmp_i(supply_high_cmp_i), .supply_low_cmp_i(supply_low_cmp_i),
    .adc_code_i(adc_code_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .serial_out_lane_zero_o(sdo), .serial_out_oe_n_o(sdo_oe_n),
    .alarm_multi_function_pin_o(alarm_pin), .alarm_pin_oe_n_o(alarm_oe_n),
    .ready_strobe_o(ready), .conv_start_o(conv_start_o), .cmd_word_o(cmd_word_o),
    .cmd_valid_o(cmd_valid_o));

  asr_host_model i_asr_host_model (.select_o(sel), .sclk_o(sclk), .sdi_o(serial_in_pin), .sdo_i(sdo),
    .sdo_oe_n_i(sdo_oe_n));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (cmd_valid_o === 1'b1) begin
      cmd_seen <= cmd_seen + 1;
      last_cmd <= cmd_word_o;
    end
    if (conv_start_o === 1'b1) conv_seen <= conv_seen + 1;
  end

  task automatic wrap_up();
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd

  task automatic wait_ready(input int lim, output int cnt);
    cnt = 0;
    while (ready !== 1'b1) begin
      @(posedge clk_i);
      #1 cnt++;
      if (cnt > lim) begin
        failures++;
        $display("Error at %0t: ready never rose", $time);
        wrap_up();
      end
    end
  endtask : wait_ready

  // A conversion with no frame, used after every release from reset.
  task automatic bare_conv();
    i_asr_host_model.set_select(1'b1);
    repeat (10) @(posedge clk_i);
    wait_ready(300, n);
  endtask : bare_conv

  task automatic counted_frame(input int bits, input logic [63:0] d);
    c_cmd = cmd_seen;
    c_conv = conv_seen;
    i_asr_host_model.frame(bits, d, dout);
    wait_ready(300, n);
    repeat (4) @(posedge clk_i);
    #1;
  endtask : counted_frame

  initial begin
    reset_i = 1'b1;
    reset_pin_n_i = 1'b1;
    supply_high_cmp_i = 1'b0;
    supply_low_cmp_i = 1'b0;
    adc_code_i = 18'h000C0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h00000000;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(ASR_OFS_HIGH_TH, v);
    check(v, ASR_RST_HIGH_TH);
    rd(ASR_OFS_LOW_TH, v);
    check(v, ASR_RST_LOW_TH);
    rd(ASR_OFS_OUT_CTL, v);
    check(v, ASR_RST_OUT_CTL);
    rd(ASR_OFS_RST_PWR, v);
    check(v, ASR_RST_RST_PWR);
    rd(8'h20, v);
    check(v, 32'h00000000);
    wr(ASR_OFS_HIGH_TH, 32'h04000100);
    wr(ASR_OFS_LOW_TH, 32'h00000050);
    wr(ASR_OFS_OUT_CTL, 32'h00000001);
    rd(ASR_OFS_HIGH_TH, v);
    check(v, 32'h04000100);
    wait_ready(4200, n);
    check(32'(n > ASR_POR_DELAY_CYC - 30), 32'h00000001);
    check(alarm_oe_n, 1'b0);
    bare_conv();
    prev_code = 18'h000C0;
    prev_act = 4'h0;
    for (int i = 0; i < 11; i++) begin
      wr(ASR_OFS_RST_PWR, (i == 10) ? 32'h00000006 : 32'h00000000);
      adc_code_i <= t_code[i];
      {supply_high_cmp_i, supply_low_cmp_i} <= t_sup[i];
      din = {32'h00000000, 16'hC3A5, 16'(i)};
      counted_frame(32, din);
      check(dout[31:0], {prev_code, prev_act, 10'h000});
      check(i_asr_host_model.oe_mid, 1'b0);
      check(sdo_oe_n, 1'b1);
      check(last_cmd, din[31:0]);
      check(cmd_seen - c_cmd, 1);
      check(conv_seen - c_conv, 1);
      check(alarm_pin, |t_act[i]);
      if (t_rd[i][8]) begin
        rd(ASR_OFS_ALARM, v);
        check(v, {24'h000000, t_rd[i][7:0]});
      end
      prev_code = t_code[i];
      prev_act = t_act[i];
    end
    counted_frame(16, 64'h000000000000ABCD);
    check(dout[15:0], prev_code[17:2]);
    check(cmd_seen - c_cmd, 0);
    check(conv_seen - c_conv, 1);
    c_cmd = cmd_seen;
    c_conv = conv_seen;
    i_asr_host_model.frame(40, 64'h000000FF12345678, dout);
    i_asr_host_model.glitch();
    wait_ready(300, n);
    repeat (4) @(posedge clk_i);
    #1 check(last_cmd, 32'h12345678);
    check(cmd_seen - c_cmd, 1);
    check(conv_seen - c_conv, 1);
    // Chained use wants the plain single-lane setting, which also releases the alarm pin.
    wr(ASR_OFS_OUT_CTL, 32'h00000000);
    @(posedge clk_i);
    #1 check(alarm_oe_n, 1'b1);
    wr(ASR_OFS_RST_PWR, 32'h00000001);
    wr(ASR_OFS_HIGH_TH, 32'h00020000);
    i_asr_host_model.set_select(1'b0);
    @(posedge clk_i);
    reset_pin_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    #1 check(ready, 1'b0);
    check(sdo_oe_n, 1'b1);
    rd(ASR_OFS_HIGH_TH, v);
    check(v, ASR_RST_HIGH_TH);
    @(posedge clk_i);
    reset_pin_n_i <= 1'b1;
    repeat (150) @(posedge clk_i);
    #1 check(ready, 1'b0);
    wait_ready(120, n);
    check(ready, 1'b1);
    rd(ASR_OFS_RST_PWR, v);
    check(v, ASR_RST_RST_PWR);
    bare_conv();
    wrap_up();
  end
endmodule : adc_serial_alarm_reset_ctrl_bench
